// [rtl/slcd_consts.svh]
// register offsets, field positions, reset values and counts of the link setup
`ifndef SLCD_CONSTS_SVH
`define SLCD_CONSTS_SVH

`define SLCD_ADDR_W          12
`define SLCD_OFF_LANE_RATE   12'h56e
`define SLCD_OFF_QUICK       12'h570
`define SLCD_OFF_LINK_CTRL   12'h574
`define SLCD_OFF_LINK_STAT   12'h575
`define SLCD_LOW_RATE_BIT    4
`define SLCD_PWR_UP_BIT      0
`define SLCD_RST_LANE_RATE   8'h00
`define SLCD_RST_QUICK       8'h88
`define SLCD_RST_LINK_CTRL   8'h00
`define SLCD_NPRIME          8'h10
`define SLCD_RATE_NUM        4'ha
`define SLCD_RATE_DEN        4'h8
`define SLCD_CS_MAX          2'h3
`define SLCD_N_MIN           5'h08
`define SLCD_N_MAX           5'h10
`define SLCD_K_DIV           4'h4

`endif

// [rtl/slcd_pkg.sv]
// types shared by the link configuration decoder
package slcd_pkg;
	typedef enum logic [1:0] {
		SLCD_DOWN,
		SLCD_APPLY,
		SLCD_UP
	} slcd_link_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] lanes;
		logic [3:0] convs;
		logic [4:0] octets;
		logic [3:0] samples;
		logic       hd;
	} slcd_cfg_t;
endpackage

// [rtl/slcd_quick_lut.sv]
// quick configuration code to transport parameter table, registered output
`timescale 1ns/1ps
`default_nettype none

module slcd_quick_lut (
	input  wire logic                i_clk,
	input  wire logic                i_rst_b,
	input  wire logic [7:0]          i_code,
	output var  slcd_pkg::slcd_cfg_t o_cfg
);
	typedef struct packed {
		slcd_pkg::slcd_cfg_t cfg;
	} slcd_lut_state_t;

	slcd_lut_state_t st_r;
	slcd_lut_state_t st_nxt;

	// --------------------------------------------------------------
	// lookup of lanes, converters, octets, samples, high density
	// --------------------------------------------------------------
	always_comb begin
		st_nxt = '{cfg: '0};
		case (i_code)
			8'h01: st_nxt.cfg = '{1'b1, 4'h1, 4'h1, 5'h02, 4'h1, 1'b0};
			8'h40: st_nxt.cfg = '{1'b1, 4'h2, 4'h1, 5'h01, 4'h1, 1'b1};
			8'h41: st_nxt.cfg = '{1'b1, 4'h2, 4'h1, 5'h02, 4'h2, 1'b0};
			8'h80: st_nxt.cfg = '{1'b1, 4'h4, 4'h1, 5'h01, 4'h2, 1'b1};
			8'h81: st_nxt.cfg = '{1'b1, 4'h4, 4'h1, 5'h02, 4'h4, 1'b0};
			8'hc0: st_nxt.cfg = '{1'b1, 4'h8, 4'h1, 5'h01, 4'h4, 1'b1};
			8'hc1: st_nxt.cfg = '{1'b1, 4'h8, 4'h1, 5'h02, 4'h8, 1'b0};
			8'h0a: st_nxt.cfg = '{1'b1, 4'h1, 4'h2, 5'h04, 4'h1, 1'b0};
			8'h49: st_nxt.cfg = '{1'b1, 4'h2, 4'h2, 5'h02, 4'h1, 1'b0};
			8'h88: st_nxt.cfg = '{1'b1, 4'h4, 4'h2, 5'h01, 4'h1, 1'b1};
			8'h89: st_nxt.cfg = '{1'b1, 4'h4, 4'h2, 5'h02, 4'h2, 1'b0};
			8'hc8: st_nxt.cfg = '{1'b1, 4'h8, 4'h2, 5'h01, 4'h2, 1'b1};
			8'hc9: st_nxt.cfg = '{1'b1, 4'h8, 4'h2, 5'h02, 4'h4, 1'b0};
			8'h13: st_nxt.cfg = '{1'b1, 4'h1, 4'h4, 5'h08, 4'h1, 1'b0};
			8'h52: st_nxt.cfg = '{1'b1, 4'h2, 4'h4, 5'h04, 4'h1, 1'b0};
			8'h91: st_nxt.cfg = '{1'b1, 4'h4, 4'h4, 5'h02, 4'h1, 1'b0};
			8'hd0: st_nxt.cfg = '{1'b1, 4'h8, 4'h4, 5'h01, 4'h1, 1'b1};
			8'hd1: st_nxt.cfg = '{1'b1, 4'h8, 4'h4, 5'h02, 4'h2, 1'b0};
			8'h1c: st_nxt.cfg = '{1'b1, 4'h1, 4'h8, 5'h10, 4'h1, 1'b0};
			8'h5b: st_nxt.cfg = '{1'b1, 4'h2, 4'h8, 5'h08, 4'h1, 1'b0};
			8'h9a: st_nxt.cfg = '{1'b1, 4'h4, 4'h8, 5'h04, 4'h1, 1'b0};
			8'hd9: st_nxt.cfg = '{1'b1, 4'h8, 4'h8, 5'h02, 4'h1, 1'b0};
			default: st_nxt.cfg = '0; // unsupported code
		endcase
	end

	// --------------------------------------------------------------
	// output register
	// --------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '{cfg: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_cfg = st_r.cfg;
endmodule // slcd_quick_lut

`default_nettype wire

// [rtl/slcd_top.sv]
// link configuration decoder: registers, quick code decode, lane rate mode
//
// Summary of operation
// - serializer clock comes from a PLL at lane rate; mode bit steers it.
// - all serial lanes belong to one single link.
// - lanes, converters and octets per frame come from the quick code.
// - lane rate is M times N' times 10/8 times output rate over L.
// - one-converter quick codes decode to the listed parameter sets.
// - two-converter quick codes decode to the listed parameter sets.
// - four and eight converter codes decode to the listed sets.
// - N is 8 to 16, N' is 16, CS 0 to 3, K divisible by 4.
`timescale 1ns/1ps
`default_nettype none
`include "slcd_consts.svh"

module slcd_top (
	input  wire logic        I_MCLK,
	input  wire logic        I_RST_B,
	input  wire logic [11:0] I_ADDR,
	input  wire logic [7:0]  I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [7:0]  O_RDATA,
	output logic             O_LINK_UP,
	output logic             O_LOW_RATE_MODE,
	output logic      [3:0]  O_LANES,
	output logic      [3:0]  O_CONVS,
	output logic      [4:0]  O_OCTETS,
	output logic      [3:0]  O_SAMPLES,
	output logic             O_HD,
	output logic      [7:0]  O_NPRIME,
	output logic      [3:0]  O_LANE_EN,
	output logic      [3:0]  O_RATE_MULT
);
	typedef struct packed {
		logic [7:0]              lane_rate;
		logic [7:0]              quick;
		logic [7:0]              link_ctrl;
		logic [7:0]              rdata;
		slcd_pkg::slcd_link_t    link;
		slcd_pkg::slcd_cfg_t     act;
		logic                    low_rate;
		logic                    bad_code;
		logic [3:0]              lane_en;
		logic [3:0]              rate_mult;
	} slcd_state_t;

	logic                rst_s1_r;
	logic                rst_b_r;
	slcd_state_t         st_r;
	slcd_state_t         st_nxt;
	slcd_pkg::slcd_cfg_t lut_cfg;

	// --------------------------------------------------------------
	// reset release through two flip-flops
	// --------------------------------------------------------------
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rst_s1_r <= 1'b0;
			rst_b_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_b_r  <= rst_s1_r;
		end
	end

	// --------------------------------------------------------------
	// quick code table
	// --------------------------------------------------------------
	slcd_quick_lut u_lut (
		.i_clk   (I_MCLK),
		.i_rst_b (rst_b_r),
		.i_code  (st_r.quick),
		.o_cfg   (lut_cfg)
	);

	// --------------------------------------------------------------
	// register writes, power sequence and read data
	// --------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = 8'h00;
		if (I_WR) begin
			case (I_ADDR)
				`SLCD_OFF_LANE_RATE: st_nxt.lane_rate = I_WDATA;
				`SLCD_OFF_QUICK:     st_nxt.quick = I_WDATA;
				`SLCD_OFF_LINK_CTRL: st_nxt.link_ctrl = I_WDATA;
				default: st_nxt.lane_rate = st_r.lane_rate;
			endcase
		end
		// link power state: setup is latched only on the power-up step
		case (st_r.link)
			slcd_pkg::SLCD_DOWN: begin
				if (st_r.link_ctrl[`SLCD_PWR_UP_BIT]) begin
					st_nxt.link = slcd_pkg::SLCD_APPLY;
				end
			end
			slcd_pkg::SLCD_APPLY: begin
				if (lut_cfg.valid) begin
					st_nxt.act = lut_cfg;
					st_nxt.bad_code = 1'b0;
				end else begin
					st_nxt.bad_code = 1'b1;
				end
				st_nxt.low_rate = st_r.lane_rate[`SLCD_LOW_RATE_BIT];
				st_nxt.link = slcd_pkg::SLCD_UP;
			end
			slcd_pkg::SLCD_UP: begin
				if (!st_r.link_ctrl[`SLCD_PWR_UP_BIT]) begin
					st_nxt.link = slcd_pkg::SLCD_DOWN;
				end
			end
			default: st_nxt.link = slcd_pkg::SLCD_DOWN;
		endcase
		// one link: lanes enabled from lane 0 upward, all one group
		case (st_r.act.lanes)
			4'h1: st_nxt.lane_en = 4'h1;
			4'h2: st_nxt.lane_en = 4'h3;
			4'h4: st_nxt.lane_en = 4'hf;
			4'h8: st_nxt.lane_en = 4'hf;
			default: st_nxt.lane_en = 4'h0;
		endcase
		if (st_r.link != slcd_pkg::SLCD_UP) begin
			st_nxt.lane_en = 4'h0;
		end
		// lane rate in units of f_out: M*16*10/8/L = M*20/L, over 2.5
		case (st_r.act.lanes)
			4'h1: st_nxt.rate_mult = {st_r.act.convs[0], 3'h0}; // wraps at 16
			4'h2: st_nxt.rate_mult = {st_r.act.convs[1:0], 2'h0};
			4'h4: st_nxt.rate_mult = {st_r.act.convs[2:0], 1'b0};
			default: st_nxt.rate_mult = st_r.act.convs;
		endcase
		if (I_RD) begin
			case (I_ADDR)
				`SLCD_OFF_LANE_RATE: st_nxt.rdata = st_r.lane_rate;
				`SLCD_OFF_QUICK:     st_nxt.rdata = st_r.quick;
				`SLCD_OFF_LINK_CTRL: st_nxt.rdata = st_r.link_ctrl;
				`SLCD_OFF_LINK_STAT: st_nxt.rdata = {5'h00, st_r.bad_code,
					st_r.low_rate, st_r.link == slcd_pkg::SLCD_UP};
				default: st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// --------------------------------------------------------------
	// state register
	// --------------------------------------------------------------
	always_ff @(posedge I_MCLK or negedge rst_b_r) begin
		if (!rst_b_r) begin
			st_r <= '{lane_rate: `SLCD_RST_LANE_RATE,
				quick: `SLCD_RST_QUICK,
				link_ctrl: `SLCD_RST_LINK_CTRL,
				rdata: 8'h00,
				link: slcd_pkg::SLCD_DOWN,
				act: '0,
				low_rate: 1'b0,
				bad_code: 1'b0,
				lane_en: 4'h0,
				rate_mult: 4'h0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// --------------------------------------------------------------
	// outputs from flip-flops, except O_LINK_UP (decoded from the link state) and O_NPRIME (a constant)
	// --------------------------------------------------------------
	assign O_RDATA         = st_r.rdata;
	assign O_LINK_UP       = (st_r.link == slcd_pkg::SLCD_UP);
	assign O_LOW_RATE_MODE = st_r.low_rate;
	assign O_LANES         = st_r.act.lanes;
	assign O_CONVS         = st_r.act.convs;
	assign O_OCTETS        = st_r.act.octets;
	assign O_SAMPLES       = st_r.act.samples;
	assign O_HD            = st_r.act.hd;
	assign O_NPRIME        = `SLCD_NPRIME;
	assign O_LANE_EN       = st_r.lane_en;
	assign O_RATE_MULT     = st_r.rate_mult;
endmodule // slcd_top

`default_nettype wire

// [tb/slcd_chk.sv]
// port checker of the link configuration decoder
`timescale 1ns/1ps
`default_nettype none
`include "slcd_consts.svh"
module slcd_chk (
	input wire logic        I_MCLK,
	input wire logic        I_RST_B,
	input wire logic [11:0] I_ADDR,
	input wire logic [7:0]  I_WDATA,
	input wire logic        I_WR,
	input wire logic        I_RD,
	input wire logic [7:0]  O_RDATA,
	input wire logic        O_LINK_UP,
	input wire logic        O_LOW_RATE_MODE,
	input wire logic [3:0]  O_LANES,
	input wire logic [3:0]  O_CONVS,
	input wire logic [4:0]  O_OCTETS,
	input wire logic [3:0]  O_SAMPLES,
	input wire logic        O_HD,
	input wire logic [7:0]  O_NPRIME,
	input wire logic [3:0]  O_LANE_EN,
	input wire logic [3:0]  O_RATE_MULT
);
	logic       up_d_r;
	logic [3:0] lane_exp;
	logic [7:0] rate_exp;
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_B);
	// link state one cycle back, so lagging outputs can be judged
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B)
			up_d_r <= 1'b0;
		else
			up_d_r <= O_LINK_UP;
	end
	// lane enables and rate multiplier implied by the applied setup
	assign lane_exp = (O_LANES == 4'h1) ? 4'h1 : (O_LANES == 4'h2) ? 4'h3 : 4'hf;
	assign rate_exp = ({4'h0, O_CONVS} << 3) / {4'h0, O_LANES};
	sequence s_up_req;
		I_WR && I_ADDR == `SLCD_OFF_LINK_CTRL && I_WDATA[0] && !O_LINK_UP;
	endsequence
	sequence s_dn_req;
		I_WR && I_ADDR == `SLCD_OFF_LINK_CTRL && !I_WDATA[0] && O_LINK_UP;
	endsequence
	a_rdata_idle: assert property (!I_RD |=> O_RDATA == 8'h00)
		else $error("read data not idle");
	a_nprime_fixed: assert property (O_NPRIME == `SLCD_NPRIME)
		else $error("sample width not sixteen");
	a_power_up_seq: assert property (s_up_req |=> (!O_LINK_UP)[*2] ##1 O_LINK_UP)
		else $error("link not up three cycles after request");
	a_power_down: assert property (s_dn_req |-> ##[1:2] !O_LINK_UP)
		else $error("link not down after request");
	a_lane_late: assert property ($rose(O_LINK_UP) |-> O_LANE_EN == 4'h0 ##1 O_LANE_EN != 4'h0)
		else $error("lane enables not one cycle after link up");
	a_lane_map: assert property (up_d_r && O_LINK_UP |-> O_LANE_EN == lane_exp)
		else $error("lane enables do not match lane count");
	a_rate_mult: assert property (up_d_r && O_LINK_UP && rate_exp < 8'h10 |-> O_RATE_MULT == rate_exp[3:0])
		else $error("rate multiplier wrong");
	a_params_hold: assert property (up_d_r && O_LINK_UP |-> $stable({O_LANES, O_CONVS, O_OCTETS, O_SAMPLES, O_HD, O_LOW_RATE_MODE}))
		else $error("setup changed while link up");
endmodule // slcd_chk
bind slcd_top slcd_chk chk_u (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
	.O_LINK_UP(O_LINK_UP), .O_LOW_RATE_MODE(O_LOW_RATE_MODE), .O_LANES(O_LANES),
	.O_CONVS(O_CONVS), .O_OCTETS(O_OCTETS), .O_SAMPLES(O_SAMPLES), .O_HD(O_HD),
	.O_NPRIME(O_NPRIME), .O_LANE_EN(O_LANE_EN), .O_RATE_MULT(O_RATE_MULT));
`default_nettype wire

// [tb/slcd_rx_model.sv]
// far-end receiver model counting the lanes it is offered
`timescale 1ns/1ps
`default_nettype none
module slcd_rx_model (
	input  wire logic       i_clk,
	input  wire logic       i_link_up,
	input  wire logic [3:0] i_lane_en,
	output var  logic [2:0] o_lanes_seen
);
	// every enabled lane joins the one link, only while it is up
	always_ff @(posedge i_clk) begin
		o_lanes_seen <= i_link_up ? 3'($countones(i_lane_en)) : 3'h0;
	end
endmodule // slcd_rx_model
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench of the link configuration decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  rdata, nprime;
	logic [3:0]  lanes, convs, samples, lane_en, rate_mult;
	logic [4:0]  octets;
	logic        link_up, low_rate, hd;
	logic [2:0]  seen;
	int          err_total = 0;
	int          samples_checked = 0;
	// quick code, converters, samples per frame
	logic [15:0] tbl [22] = '{16'h0111, 16'h4011, 16'h4112, 16'h8012, 16'h8114,
		16'hc014, 16'hc118, 16'h0a21, 16'h4921, 16'h8821, 16'h8922, 16'hc822,
		16'hc924, 16'h1341, 16'h5241, 16'h9141, 16'hd041, 16'hd142, 16'h1c81,
		16'h5b81, 16'h9a81, 16'hd981};
	initial forever #2.5 clk = ~clk;
	slcd_top dut_u (.I_MCLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_LINK_UP(link_up),
		.O_LOW_RATE_MODE(low_rate), .O_LANES(lanes), .O_CONVS(convs),
		.O_OCTETS(octets), .O_SAMPLES(samples), .O_HD(hd), .O_NPRIME(nprime),
		.O_LANE_EN(lane_en), .O_RATE_MULT(rate_mult));
	slcd_rx_model rx_u (.i_clk(clk), .i_link_up(link_up), .i_lane_en(lane_en),
		.o_lanes_seen(seen));
	// ----------------------------------------
	// bus cycles and comparison
	// ----------------------------------------
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 cmp(rdata, e);
	endtask
	task automatic conclude();
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// host side: pick an output rate that keeps the lane rate legal
	function automatic logic [7:0] lr_pick(input logic [15:0] t);
		int m, l, lo, hi, f, rate;
		m = t[7:4];
		l = 1 << t[15:14];
		lo = (3125 * l + m * 20 - 1) / (m * 20);
		hi = 12500 * l / (m * 20);
		f = $urandom_range(hi, lo);
		rate = m * 20 * f / l;
		return (rate < 6250) ? 8'h10 : 8'h00;
	endfunction
	// down, pick code and rate mode, up, then judge the applied setup
	task automatic run_cfg(input logic [15:0] t, input logic [7:0] lr);
		logic [7:0] l;
		logic [7:0] f;
		logic [7:0] r;
		l = 8'h01 << t[15:14];
		f = {4'h0, t[7:4]} * {4'h0, t[3:0]} * 8'h02 / l;
		r = {4'h0, t[7:4]} * 8'h08 / l;
		wr_reg(12'h574, 8'h00);
		wr_reg(12'h570, t[15:8]);
		wr_reg(12'h56e, lr);
		wr_reg(12'h574, 8'h01);
		repeat (4) @(posedge clk);
		#1 cmp({4'h0, lanes}, l);
		cmp({4'h0, convs}, {4'h0, t[7:4]});
		cmp({3'h0, octets}, f);
		cmp({4'h0, samples}, {4'h0, t[3:0]});
		cmp({7'h0, hd}, {7'h0, f == 8'h01});
		cmp({7'h0, low_rate}, {7'h0, lr[4]});
		cmp({5'h0, seen}, (l > 8'h04) ? 8'h04 : l);
		if (r < 8'h10) cmp({4'h0, rate_mult}, r);
		rd_chk(12'h575, {6'h0, lr[4], 1'b1});
		$display("config %h done", t[15:8]);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(33313));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(12'h56e, 8'h00);
		rd_chk(12'h570, 8'h88);
		rd_chk(12'h574, 8'h00);
		cmp({7'h0, link_up}, 8'h00);
		$display("reset values done");
		foreach (tbl[i]) run_cfg(tbl[i], lr_pick(tbl[i]));
		for (int i = 0; i < 30; i++) begin
			int k;
			k = $urandom_range(21, 0);
			run_cfg(tbl[k], lr_pick(tbl[k]));
		end
		run_cfg(16'hd981, 8'h00);
		wr_reg(12'h574, 8'h00);
		wr_reg(12'h570, 8'hff);
		wr_reg(12'h574, 8'h01);
		repeat (4) @(posedge clk);
		rd_chk(12'h575, 8'h05);
		cmp({lanes, convs}, 8'h88);
		wr_reg(12'h570, 8'h01);
		repeat (4) @(posedge clk);
		cmp({lanes, convs}, 8'h88);
		rd_chk(12'h570, 8'h01);
		wr_reg(12'h123, 8'h5a);
		rd_chk(12'h123, 8'h00);
		$display("refusals done");
		conclude();
	end
	// watchdog cuts a hung run short
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		conclude();
	end
endmodule // testbench
`default_nettype wire
